/* File: rtl/ccdm_comm_data_map.sv */
/*
 Holding-register map of a multi-channel control unit: measured values,
 status words, rise completion, fault code, module initialization.
 Assumes a protocol engine presents one request per pulse on the same clock;
 measurement and condition inputs come from other clock domains.
*/
// How it works
// - Initialization trigger captures present module configuration as stored configuration.
// - Settings written while stale load old stored defaults into new modules in place of the written value.
// - Items are grouped per channel, per module, per logic circuit or per unit.
// - Current sense registers are read-only, reporting 0.0-100.0 A or 0.0-30.0 A.
// - Status bits: alarm1, alarm2, burnout, heater break, loop break, rise, heat.
// - Heater break bit ORs temperature module and current sense module conditions.
// - Status bit is 1 when active, word spans 0 to 127.
// - Motor speed channels keep only alarm 1, alarm 2 and heat-output bits.
// - Unit rise completion reads 0 until complete, 1 once completed.
// - Fault code register reports 0 normal through 6 adjustment data error.
// - Fractions sent as scaled integers; negatives in 16-bit two's complement.
// - Addresses above 1FFFH answer with an error response.
// - Unused channels and undefined addresses read 0; unused-channel writes dropped.
`timescale 1ns/10ps
module ccdm_comm_data_map #(
    parameter int CHANNELS = ccdm_pkg::CHANNELS,
    parameter int CONFIG_W = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [15:0] reqAddr,
    input wire logic [15:0] reqWriteData,
    output logic rspValid,
    output logic [15:0] rspReadData,
    output logic rspError,
    input wire logic [CHANNELS*16-1:0] processMeasuredValue,
    input wire logic [CHANNELS*16-1:0] motorSpeedMeasured,
    input wire logic [CHANNELS*16-1:0] heatOutputLevel,
    input wire logic [CHANNELS*16-1:0] coolOutputLevel,
    input wire logic [CHANNELS*16-1:0] currentSenseOne,
    input wire logic [CHANNELS*16-1:0] currentSenseTwo,
    input wire logic currentSenseRangeLow,
    input wire logic [CHANNELS-1:0] channelUsed,
    input wire logic [CHANNELS-1:0] channelIsSpeed,
    input wire logic [CHANNELS-1:0] alarmOne,
    input wire logic [CHANNELS-1:0] alarmTwo,
    input wire logic [CHANNELS-1:0] burnout,
    input wire logic [CHANNELS-1:0] heaterBreakTemp,
    input wire logic [CHANNELS-1:0] heaterBreakCurrent,
    input wire logic [CHANNELS-1:0] loopBreakAlarm,
    input wire logic [CHANNELS-1:0] riseDone,
    input wire logic [CHANNELS-1:0] heatOutputOn,
    input wire logic unitRiseDone,
    input wire logic [5:0] unitFaults,
    input wire logic [CONFIG_W-1:0] moduleConfig,
    output logic [CONFIG_W-1:0] storedConfig,
    output logic configStale,
    output logic settingWrite,
    output logic [4:0] settingChan,
    output logic [15:0] settingData,
    output logic loadOldDefaults
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int SYNC_W = 10 * CHANNELS + 1 + 6 + CONFIG_W + 1 + 6 * CHANNELS * 16;
    logic [SYNC_W-1:0] syncMeta;
    logic [SYNC_W-1:0] synced;

    // Everything from the measurement side is asynchronous; wide buses
    // are assumed to be held stable for many cycles around any change
    always_ff @(posedge clock) begin
        syncMeta <= {channelUsed, channelIsSpeed, alarmOne, alarmTwo, burnout, heaterBreakTemp,
                     heaterBreakCurrent, loopBreakAlarm, riseDone, heatOutputOn, unitRiseDone,
                     unitFaults, moduleConfig, currentSenseRangeLow, processMeasuredValue,
                     motorSpeedMeasured, heatOutputLevel, coolOutputLevel, currentSenseOne,
                     currentSenseTwo};
        synced <= syncMeta;
    end

    logic [CHANNELS-1:0] sUsed, sSpeed, sAl1, sAl2, sBurn, sHbT, sHbC, sLoop, sRise, sHeat;
    logic sUnitRise;
    logic [5:0] sFaults;
    logic [CONFIG_W-1:0] sConfig;
    logic sRangeLow;
    logic [CHANNELS*16-1:0] sPv, sSpd, sHeatLvl, sCoolLvl, sCt1, sCt2;
    assign {sUsed, sSpeed, sAl1, sAl2, sBurn, sHbT, sHbC, sLoop, sRise, sHeat, sUnitRise,
            sFaults, sConfig, sRangeLow, sPv, sSpd, sHeatLvl, sCoolLvl, sCt1, sCt2} = synced;

    // ************************************************************
    // Per-channel status words
    // ************************************************************
    logic [CHANNELS*16-1:0] statusWords;
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gStatus
            logic [15:0] raw;
            always_comb begin
                raw = ccdm_pkg::ZERO_WORD;
                raw[ccdm_pkg::ST_ALARM1] = sAl1[g];
                raw[ccdm_pkg::ST_ALARM2] = sAl2[g];
                raw[ccdm_pkg::ST_BURNOUT] = sBurn[g];
                raw[ccdm_pkg::ST_HEATER_BREAK] = sHbT[g] | sHbC[g];
                raw[ccdm_pkg::ST_LOOP_BREAK] = sLoop[g];
                raw[ccdm_pkg::ST_RISE_DONE] = sRise[g];
                raw[ccdm_pkg::ST_HEAT_OUT] = sHeat[g];
            end
            // Speed channels carry only the two alarms and heat output
            assign statusWords[g*16 +: 16] = sSpeed[g] ? (raw & ccdm_pkg::SPEED_STATUS_MASK) : raw;
        end
    endgenerate

    // ************************************************************
    // Fault code
    // ************************************************************
    ccdm_pkg::ccdm_fault_t faultCode;

    ccdm_fault_encoder uFault (
        .faults(sFaults),
        .code(faultCode)
    );

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic inBlock(input logic [15:0] addr, input logic [15:0] base);
        inBlock = ((addr & ccdm_pkg::BLOCK_MASK) == base) && (int'(addr[4:0]) < CHANNELS);
    endfunction

    function automatic logic [15:0] pick(input logic [CHANNELS*16-1:0] bus, input logic [4:0] ch);
        pick = bus[ch*16 +: 16];
    endfunction

    logic [4:0] chan;
    logic chanUsed;
    assign chan = reqAddr[4:0];
    assign chanUsed = (int'(chan) < CHANNELS) ? sUsed[chan] : 1'b0;

    // Current sense saturates at the selected full scale
    function automatic logic [15:0] clampCurrent(input logic [15:0] v, input logic low);
        logic [15:0] lim;
        lim = low ? ccdm_pkg::CURRENT_FULL_LOW : ccdm_pkg::CURRENT_FULL_HIGH;
        clampCurrent = (v > lim) ? lim : v;
    endfunction

    // Measured values other than current sense pass through as signed scaled integers untouched
    logic [15:0] next_readData;
    always_comb begin
        next_readData = ccdm_pkg::ZERO_WORD;
        if (inBlock(reqAddr, ccdm_pkg::BASE_PROCESS_VALUE) && chanUsed) begin
            next_readData = pick(sPv, chan);
        end else if (inBlock(reqAddr, ccdm_pkg::BASE_MOTOR_SPEED) && chanUsed) begin
            next_readData = pick(sSpd, chan);
        end else if (inBlock(reqAddr, ccdm_pkg::BASE_HEAT_OUTPUT) && chanUsed) begin
            next_readData = pick(sHeatLvl, chan);
        end else if (inBlock(reqAddr, ccdm_pkg::BASE_COOL_OUTPUT) && chanUsed) begin
            next_readData = pick(sCoolLvl, chan);
        end else if (inBlock(reqAddr, ccdm_pkg::BASE_CURRENT_ONE) && chanUsed) begin
            next_readData = clampCurrent(pick(sCt1, chan), sRangeLow);
        end else if (inBlock(reqAddr, ccdm_pkg::BASE_CURRENT_TWO) && chanUsed) begin
            next_readData = clampCurrent(pick(sCt2, chan), sRangeLow);
        end else if (inBlock(reqAddr, ccdm_pkg::BASE_STATUS) && chanUsed) begin
            next_readData = pick(statusWords, chan);
        end else if (reqAddr == ccdm_pkg::ADDR_RISE_DONE) begin
            next_readData = {15'h0000, sUnitRise};
        end else if (reqAddr == ccdm_pkg::ADDR_FAULT_CODE) begin
            next_readData = faultCode;
        end else if (reqAddr == ccdm_pkg::ADDR_CONFIG_STALE) begin
            next_readData = {15'h0000, configStale};
        end
    end

    // ************************************************************
    // Response
    // ************************************************************
    logic outOfRange;
    assign outOfRange = reqAddr > ccdm_pkg::ADDR_LIMIT;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rspValid <= 1'b0;
            rspError <= 1'b0;
        end else begin
            rspValid <= reqValid;
            rspError <= reqValid & outOfRange;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rspReadData <= ccdm_pkg::ZERO_WORD;
        end else if (reqValid) begin
            // Writes and errors answer with zero; read-only data is never altered
            rspReadData <= (!reqWrite && !outOfRange) ? next_readData : ccdm_pkg::ZERO_WORD;
        end
    end

    // ************************************************************
    // Module initialization and stored configuration
    // ************************************************************
    logic initHit;
    assign initHit = reqValid & reqWrite & (reqAddr == ccdm_pkg::ADDR_MODULE_INIT);

    // Hazard: until a configuration is captured the stored one is all zero,
    // so any fitted module makes the unit report a stale configuration
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            storedConfig <= '0;
        end else if (initHit) begin
            storedConfig <= sConfig;
        end
    end

    assign configStale = (storedConfig != sConfig);

    // ************************************************************
    // Setting writes, per channel
    // ************************************************************
    logic settingHit;
    assign settingHit = reqValid & reqWrite & inBlock(reqAddr, ccdm_pkg::BASE_SETTING);

    ccdm_setting_if settingBus ();

    assign settingBus.writeEn = settingHit & chanUsed;
    assign settingBus.writeChan = chan;
    assign settingBus.writeData = reqWriteData;
    assign settingBus.readChan = chan;

    ccdm_setting_store #(
        .DEPTH(CHANNELS)
    ) uStore (
        .clock(clock),
        .port(settingBus.owner)
    );

    // Stale configuration: the old stored default goes out one cycle late in place
    // of the written value, which only reaches the store, mirroring the unit's documented hazard
    logic pendingStale;
    logic [15:0] pendingData;
    logic [4:0] pendingChan;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pendingStale <= 1'b0;
            pendingData <= ccdm_pkg::ZERO_WORD;
            pendingChan <= 5'h00;
        end else begin
            pendingStale <= settingHit & chanUsed & configStale;
            pendingData <= reqWriteData;
            pendingChan <= chan;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            settingWrite <= 1'b0;
            settingChan <= 5'h00;
            settingData <= ccdm_pkg::ZERO_WORD;
            loadOldDefaults <= 1'b0;
        end else if (pendingStale) begin
            settingWrite <= 1'b1;
            settingChan <= pendingChan;
            settingData <= settingBus.readData;
            loadOldDefaults <= 1'b1;
        end else begin
            settingWrite <= settingHit & chanUsed & ~configStale;
            settingChan <= chan;
            settingData <= reqWriteData;
            loadOldDefaults <= 1'b0;
        end
    end
endmodule

/* File: common/ccdm_pkg.sv */
/*
 Package for the controller communication data map: register indices,
 status bit positions, fault codes and sizing constants.
 Assumes the holding-register address is a 16-bit word index.
*/
package ccdm_pkg;

    // ************************************************************
    // Sizing
    // ************************************************************
    localparam int CHANNELS = 20;
    localparam int CH_BITS = 5;
    localparam int WORD_W = 16;

    // ************************************************************
    // Address space and register bases
    // ************************************************************
    localparam logic [15:0] ADDR_LIMIT = 16'h1FFF;
    localparam logic [15:0] BASE_PROCESS_VALUE = 16'h0000;
    localparam logic [15:0] BASE_MOTOR_SPEED = 16'h0020;
    localparam logic [15:0] BASE_HEAT_OUTPUT = 16'h0040;
    localparam logic [15:0] BASE_COOL_OUTPUT = 16'h0060;
    localparam logic [15:0] BASE_CURRENT_ONE = 16'h0080;
    localparam logic [15:0] BASE_CURRENT_TWO = 16'h00A0;
    localparam logic [15:0] BASE_STATUS = 16'h00C0;
    localparam logic [15:0] ADDR_RISE_DONE = 16'h00E0;
    localparam logic [15:0] ADDR_FAULT_CODE = 16'h00E1;
    localparam logic [15:0] ADDR_CONFIG_STALE = 16'h00E2;
    localparam logic [15:0] ADDR_MODULE_INIT = 16'h02BF;
    localparam logic [15:0] BASE_SETTING = 16'h0100;
    localparam logic [15:0] BLOCK_MASK = 16'hFFE0;

    // ************************************************************
    // Status word bit positions
    // ************************************************************
    localparam int ST_ALARM1 = 0;
    localparam int ST_ALARM2 = 1;
    localparam int ST_BURNOUT = 2;
    localparam int ST_HEATER_BREAK = 3;
    localparam int ST_LOOP_BREAK = 4;
    localparam int ST_RISE_DONE = 5;
    localparam int ST_HEAT_OUT = 6;
    localparam logic [15:0] SPEED_STATUS_MASK = 16'h0043;

    // ************************************************************
    // Current sense full-scale values, tenths of an ampere
    // ************************************************************
    localparam logic [15:0] CURRENT_FULL_HIGH = 16'h03E8;
    localparam logic [15:0] CURRENT_FULL_LOW = 16'h012C;

    // ************************************************************
    // Fault codes
    // ************************************************************
    typedef enum logic [15:0] {
        FAULT_NONE = 16'h0000,
        FAULT_BACKUP = 16'h0001,
        FAULT_RAM = 16'h0002,
        FAULT_STRUCTURE = 16'h0003,
        FAULT_INTERNAL_COMM = 16'h0004,
        FAULT_ADC = 16'h0005,
        FAULT_ADJUST = 16'h0006
    } ccdm_fault_t;

    // Structure classes of data items
    typedef enum logic [1:0] {
        CLASS_CHANNEL,
        CLASS_MODULE,
        CLASS_LOGIC,
        CLASS_UNIT
    } ccdm_class_t;

    localparam logic [15:0] ZERO_WORD = 16'h0000;

endpackage

/* File: common/ccdm_setting_if.sv */
/*
 Interface between the map and its per-channel setting store.
 Assumes one writer and one reader on the shared clock.
*/
`timescale 1ns/10ps
interface ccdm_setting_if;
    logic writeEn;
    logic [4:0] writeChan;
    logic [15:0] writeData;
    logic [4:0] readChan;
    logic [15:0] readData;

    modport owner (output writeEn, output writeChan, output writeData, output readChan, input readData);
    modport store (input writeEn, input writeChan, input writeData, input readChan, output readData);
endinterface

/* File: rtl/ccdm_setting_store.sv */
/*
 Small memory holding one setting word per channel; read data registered.
 Assumes the owner presents the read channel one cycle ahead of use.
*/
`timescale 1ns/10ps
module ccdm_setting_store #(
    parameter int DEPTH = 20
) (
    input wire logic clock,
    ccdm_setting_if.store port
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (port.writeEn && (int'(port.writeChan) < DEPTH)) begin
            mem[port.writeChan] <= port.writeData;
        end
    end

    always_ff @(posedge clock) begin
        if (int'(port.readChan) < DEPTH) begin
            port.readData <= mem[port.readChan];
        end else begin
            port.readData <= 16'h0000;
        end
    end
endmodule

/* File: rtl/ccdm_fault_encoder.sv */
/*
 Priority encoder from raw fault conditions to the unit fault code.
 Assumes raw fault inputs are already synchronised to clock.
*/
`timescale 1ns/10ps
module ccdm_fault_encoder (
    input wire logic [5:0] faults,
    output ccdm_pkg::ccdm_fault_t code
);
    // Lowest numbered fault wins when several are active at once
    always_comb begin
        code = ccdm_pkg::FAULT_NONE;
        if (faults[0]) begin
            code = ccdm_pkg::FAULT_BACKUP;
        end else if (faults[1]) begin
            code = ccdm_pkg::FAULT_RAM;
        end else if (faults[2]) begin
            code = ccdm_pkg::FAULT_STRUCTURE;
        end else if (faults[3]) begin
            code = ccdm_pkg::FAULT_INTERNAL_COMM;
        end else if (faults[4]) begin
            code = ccdm_pkg::FAULT_ADC;
        end else if (faults[5]) begin
            code = ccdm_pkg::FAULT_ADJUST;
        end
    end
endmodule

/* File: test/ccdm_map_properties.sv */
/*
 Concurrent checks on the data map ports.
 Assumes it is bound onto ccdm_comm_data_map.
*/
`timescale 1ns/10ps
module ccdm_map_properties #(
    parameter int CHANNELS = 20,
    parameter int CONFIG_W = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [15:0] reqAddr,
    input wire logic rspValid,
    input wire logic [15:0] rspReadData,
    input wire logic rspError,
    input wire logic [CHANNELS-1:0] channelUsed,
    input wire logic [CONFIG_W-1:0] moduleConfig,
    input wire logic [CONFIG_W-1:0] storedConfig,
    input wire logic configStale,
    input wire logic settingWrite
);
    // ********
    // Properties
    // ********
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic isRead = reqValid && !reqWrite;
    wire logic [15:0] block = reqAddr & ccdm_pkg::BLOCK_MASK;
    // Index only read when the channel field is in range
    wire logic unusedWr = reqValid && reqWrite && block == ccdm_pkg::BASE_SETTING
        && int'(reqAddr[4:0]) < CHANNELS && !channelUsed[reqAddr[4:0]];
    a_answer_follows: assert property (reqValid |=> rspValid)
        else $error("request without answer");
    a_no_spurious: assert property (!reqValid |=> !rspValid)
        else $error("answer without request");
    a_range_error: assert property (reqValid && reqAddr > ccdm_pkg::ADDR_LIMIT |=> rspError && rspReadData == 0)
        else $error("out of range access not refused");
    a_range_ok: assert property (reqValid && reqAddr <= ccdm_pkg::ADDR_LIMIT |=> !rspError)
        else $error("in range access refused");
    a_write_quiet: assert property (reqValid && reqWrite |=> rspReadData == 16'h0000)
        else $error("write returned data");
    a_status_span: assert property (isRead && block == ccdm_pkg::BASE_STATUS |=> rspReadData[15:7] == 9'h000)
        else $error("status word above 127");
    a_rise_binary: assert property (isRead && reqAddr == ccdm_pkg::ADDR_RISE_DONE |=> rspReadData[15:1] == 15'h0000)
        else $error("rise flag not 0 or 1");
    a_fault_codes: assert property (isRead && reqAddr == ccdm_pkg::ADDR_FAULT_CODE |=> rspReadData <= 16'h0006)
        else $error("fault code out of list");
    a_init_capture: assert property (reqValid && reqWrite && reqAddr == ccdm_pkg::ADDR_MODULE_INIT
        && $stable(moduleConfig) && moduleConfig == $past(moduleConfig, 3)
        |=> ##1 !configStale && storedConfig == moduleConfig)
        else $error("configuration not captured");
    a_unused_drop: assert property (unusedWr && !configStale && $stable(channelUsed) |=> !settingWrite [*2])
        else $error("unused channel write passed on");
endmodule
bind ccdm_comm_data_map ccdm_map_properties #(.CHANNELS(CHANNELS), .CONFIG_W(CONFIG_W)) u_ccdm_map_properties (
    .clock(clock), .reset_n(reset_n), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .rspValid(rspValid), .rspReadData(rspReadData), .rspError(rspError), .channelUsed(channelUsed),
    .moduleConfig(moduleConfig), .storedConfig(storedConfig), .configStale(configStale),
    .settingWrite(settingWrite));

/* File: test/ccdm_master_model.sv */
/*
 Protocol master model issuing single-word holding-register accesses.
 Assumes requests are launched on the falling edge of clock.
*/
`timescale 1ns/10ps
module ccdm_master_model (
    input wire logic clock,
    output logic reqValid,
    output logic reqWrite,
    output logic [15:0] reqAddr,
    output logic [15:0] reqWriteData,
    input wire logic rspValid,
    input wire logic [15:0] rspReadData,
    input wire logic rspError
);
    initial begin
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 16'hFFFF;
        reqWriteData = 16'h0000;
    end
    // ********
    // One access: request taken at the next rising edge, answer one cycle on
    // ********
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] rd, output logic err, output logic ok);
        @(negedge clock);
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqWriteData = d;
        @(negedge clock);
        ok = rspValid;
        rd = rspReadData;
        err = rspError;
        reqValid = 1'b0;
        // Idle qualifiers flip so a stale address can never look valid
        reqWrite = ~wr;
        reqAddr = ~a;
        reqWriteData = ~d;
    endtask
endmodule

/* File: test/ccdm_comm_data_map_test.sv */
/*
 Self-checking bench for the data map.
 Assumes the default sizing of 20 channels and a 32-bit configuration word.
*/
`timescale 1ns/10ps
module ccdm_comm_data_map_test;
    localparam int CH = 20;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic reqValid, reqWrite, rspValid, rspError, unitRiseDone, configStale, settingWrite, loadOldDefaults;
    logic [15:0] reqAddr, reqWriteData, rspReadData, settingData;
    logic [CH*16-1:0] meas [6];
    logic [CH-1:0] cond [8];
    logic [CH-1:0] channelUsed = 20'h7FFFF;
    logic [CH-1:0] channelIsSpeed = 20'h00020;
    logic currentSenseRangeLow = 1'b0;
    logic [5:0] unitFaults;
    logic [31:0] moduleConfig, storedConfig;
    logic [4:0] settingChan;
    int num_errors = 0;
    int cmp_count = 0;
    always #5 clock = ~clock;
    ccdm_comm_data_map u_ccdm_comm_data_map (.clock(clock), .reset_n(reset_n), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWriteData(reqWriteData), .rspValid(rspValid),
        .rspReadData(rspReadData), .rspError(rspError), .processMeasuredValue(meas[0]),
        .motorSpeedMeasured(meas[1]), .heatOutputLevel(meas[2]), .coolOutputLevel(meas[3]),
        .currentSenseOne(meas[4]), .currentSenseTwo(meas[5]), .currentSenseRangeLow(currentSenseRangeLow),
        .channelUsed(channelUsed), .channelIsSpeed(channelIsSpeed), .alarmOne(cond[0]), .alarmTwo(cond[1]),
        .burnout(cond[2]), .heaterBreakTemp(cond[3]), .loopBreakAlarm(cond[4]), .riseDone(cond[5]),
        .heatOutputOn(cond[6]), .heaterBreakCurrent(cond[7]), .unitRiseDone(unitRiseDone),
        .unitFaults(unitFaults), .moduleConfig(moduleConfig), .storedConfig(storedConfig),
        .configStale(configStale), .settingWrite(settingWrite), .settingChan(settingChan),
        .settingData(settingData), .loadOldDefaults(loadOldDefaults));
    ccdm_master_model u_ccdm_master_model (.clock(clock), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqWriteData(reqWriteData), .rspValid(rspValid), .rspReadData(rspReadData),
        .rspError(rspError));
    // ********
    // Helpers
    // ********
    // Negative words for the signed quantities, amperes within the 100 A full scale for current sense
    function automatic logic [15:0] mval(int k, int ch);
        return (k < 4) ? 16'hFF38 - 16'(k * 32 + ch) : 16'h00C8 + 16'(k * 32 + ch);
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] wd,
        output logic [15:0] d, output logic e);
        logic ok;
        u_ccdm_master_model.access(w, a, wd, d, e, ok);
        chk("rspValid", 32'h1, 32'(ok));
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic test_measured;
        logic [15:0] d;
        logic e;
        for (int k = 0; k < 6; k++) begin
            xfer(1'b0, 16'(k * 32 + 3), 16'h0000, d, e);
            chk("measured", 32'(mval(k, 3)), 32'(d));
            xfer(1'b0, 16'(k * 32 + 19), 16'h0000, d, e);
            chk("unused channel", 32'h0, 32'(d));
        end
        xfer(1'b1, 16'h0083, 16'h7777, d, e);
        xfer(1'b0, 16'h0083, 16'h0000, d, e);
        chk("current sense", 32'(mval(4, 3)), 32'(d));
        // Channel 3 sits above the 30 A full scale, so the low range must saturate it
        currentSenseRangeLow = 1'b1;
        repeat (4) @(negedge clock);
        xfer(1'b0, 16'h0083, 16'h0000, d, e);
        chk("current clamp", 32'(ccdm_pkg::CURRENT_FULL_LOW), 32'(d));
        currentSenseRangeLow = 1'b0;
    endtask
    task automatic test_status;
        logic [15:0] d, exp;
        logic e;
        for (int b = 0; b < 9; b++) begin
            for (int i = 0; i < 8; i++) cond[i] = (b == 8 || b == i) ? 20'h00024 : 20'h00000;
            repeat (4) @(negedge clock);
            exp = (b == 8) ? 16'h007F : 16'h0001 << ((b == 7) ? 3 : b);
            xfer(1'b0, 16'h00C2, 16'h0000, d, e);
            chk("status", 32'(exp), 32'(d));
            xfer(1'b0, 16'h00C5, 16'h0000, d, e);
            chk("speed status", 32'(exp & 16'h0043), 32'(d));
        end
    endtask
    task automatic test_unit;
        logic [15:0] d;
        logic e;
        for (int r = 0; r < 2; r++) begin
            unitRiseDone = r[0];
            repeat (4) @(negedge clock);
            xfer(1'b0, ccdm_pkg::ADDR_RISE_DONE, 16'h0000, d, e);
            chk("rise done", 32'(r), 32'(d));
        end
        for (int i = 0; i < 7; i++) begin
            unitFaults = (i == 0) ? 6'h00 : 6'h3F << (i - 1);
            repeat (4) @(negedge clock);
            xfer(1'b0, ccdm_pkg::ADDR_FAULT_CODE, 16'h0000, d, e);
            chk("fault code", 32'(i), 32'(d));
        end
    endtask
    task automatic test_range;
        logic [15:0] d;
        logic e;
        xfer(1'b0, 16'h2000, 16'h0000, d, e);
        chk("error beyond limit", 32'h1, 32'(e));
        xfer(1'b1, 16'hFFFF, 16'h1111, d, e);
        chk("write beyond limit", 32'h1, 32'(e));
        xfer(1'b0, 16'h1FFF, 16'h0000, d, e);
        chk("undefined read", 32'h0, 32'({e, d}));
        xfer(1'b1, 16'h0113, 16'h2222, d, e);
        chk("unused write", 32'h0, 32'({e, settingWrite}));
    endtask
    task automatic test_config;
        logic [15:0] d;
        logic e;
        xfer(1'b1, 16'h0102, 16'h1234, d, e);
        chk("fresh write", 32'h0042_1234, 32'({settingWrite, loadOldDefaults, settingChan, settingData}));
        moduleConfig = 32'h0000_00A5;
        repeat (4) @(negedge clock);
        chk("stale", 32'h1, 32'(configStale));
        xfer(1'b1, 16'h0102, 16'h5678, d, e);
        chk("stale delay", 32'h0, 32'(settingWrite));
        @(negedge clock);
        chk("old default", 32'h0062_1234, 32'({settingWrite, loadOldDefaults, settingChan, settingData}));
        xfer(1'b1, ccdm_pkg::ADDR_MODULE_INIT, 16'h0001, d, e);
        repeat (2) @(negedge clock);
        chk("stored config", 32'h0000_00A5, storedConfig);
        chk("stale cleared", 32'h0, 32'(configStale));
        xfer(1'b1, 16'h0102, 16'h9ABC, d, e);
        chk("write after init", 32'h0042_9ABC, 32'({settingWrite, loadOldDefaults, settingChan, settingData}));
    endtask
    initial begin
        for (int k = 0; k < 6; k++) for (int c = 0; c < CH; c++) meas[k][16 * c +: 16] = mval(k, c);
        for (int i = 0; i < 8; i++) cond[i] = 20'h00000;
        unitRiseDone = 1'b0;
        unitFaults = 6'h00;
        moduleConfig = 32'h0000_0000;
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        test_measured();
        test_status();
        test_unit();
        test_range();
        test_config();
        end_sim();
    end
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
endmodule
